// >>> slave_select_defs.vh
// Register offsets, field positions, reset values and timing constants of the slave-select bank
`ifndef SLAVE_SELECT_DEFS_VH
`define SLAVE_SELECT_DEFS_VH

// Register byte offsets
`define OFF_DMA_STATUS      8'hBF
`define OFF_SW0_CONTROL     8'hC3
`define OFF_SW0_TIMING      8'hC7
`define OFF_SW1_CONTROL     8'hCB
`define OFF_SW1_TIMING      8'hCF

// Reset values
`define RST_DMA_STATUS      8'h00
`define RST_CONTROL         8'h00
`define RST_TIMING          8'h00

// dma_status fields
`define DS_BLT_BUSY         0
`define DS_DMA_LOCAL_BUS_ERROR_N        1
`define DS_DMA_BERR         2
`define DS_LOCAL_BUS_ERROR_N_COPY       3
`define DS_BERR_COPY        4
`define DS_RSVD_LO          5
`define DS_RSVD_HI          6
`define DS_POST_STORED      7

// Control fields
`define CR_MODE_LO          0
`define CR_SPACE_LO         2
`define CR_D32              4
`define CR_SUPER            5
`define CR_TIMER_LO         6
`define CR_MPOST            6
`define CR_SPOST            7

// Local transfer modes
`define MODE_NONE           2'h0
`define MODE_EMULATE        2'h1
`define MODE_HOLD           2'h2

// Address spaces
`define SPACE_A32           2'h0
`define SPACE_A24           2'h1
`define SPACE_A16           2'h2
`define SPACE_USER          2'h3

// Address modifier bit that marks supervisory access
`define AM_SUPER_BIT        2

// Timer periods and system clock rate
`define CLK_HZ              100000000
`define TIMER_HZ_50         50
`define TIMER_HZ_1000       1000
`define TIMER_HZ_100        100
// Half-period counts: clock rate over twice the tone rate, sized for the counter
`define HALF_50             24'h0F_4240
`define HALF_1000           24'h00_C350
`define HALF_100            24'h07_A120

// Delay encoding: code n (n >= 1) gives (n + 3) half periods of the 64 MHz clock
`define DELAY_HALF_BASE     5'h03

`endif

// >>> slave_select_bank.v
// Status and slave-select window configuration registers with slave decode and delay outputs
`timescale 1ns/1ns
`default_nettype none
`include "slave_select_defs.vh"

module slave_select_bank #(
  parameter [23:0] HALF_50_CNT   = `HALF_50,
  parameter [23:0] HALF_1000_CNT = `HALF_1000,
  parameter [23:0] HALF_100_CNT  = `HALF_100
) (
  input  wire       clk_sys,
  input  wire       nrst,
  input  wire       clk_en,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Event inputs from the transfer engines
  input  wire       blt_interleave_active,
  input  wire       dma_active,
  input  wire       local_bus_error_n,
  input  wire       backplane_berr_n,
  input  wire       local_bus_error_n_status,
  input  wire       berr_status,
  input  wire       master_post_stored,
  input  wire [5:0] address_modifier_source,
  // Incoming backplane slave access
  input  wire       slave_window0_select_n,
  input  wire       slave_window1_select_n,
  input  wire [5:0] am_code,
  input  wire       am_is_block,
  input  wire       access_d32,
  input  wire       block_beat,
  input  wire       block_cycle_start,
  // Decode results
  output reg        slave_accept,
  output reg        slave_berr,
  output reg        master_dma_block_en,
  output reg        local_address_strobe_hold,
  output reg        local_address_strobe_toggle,
  output reg        byte_lane_buffer_enable_n,
  output reg        swap_data_enable_n,
  output reg        local_interrupt2_n,
  output reg        master_post_en,
  output reg        slave_post_en,
  // Delays in half periods of the 64 MHz clock
  output reg  [4:0] single_access_delay,
  output reg  [4:0] slave_block_first_delay,
  output reg  [4:0] slave_block_next_delay,
  output reg  [4:0] master_block_first_delay,
  output reg  [4:0] master_block_next_delay,
  output reg  [4:0] module_dma_first_delay,
  output reg  [4:0] module_dma_next_delay
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Code to half periods: 0 -> 0, n -> n + 3 (2.0 periods at code 1)
  function [4:0] delay_halves;
    input [3:0] code;
    begin
      if (code == 4'h0) begin
        delay_halves = 5'h00;
      end else begin
        delay_halves = {1'b0, code} + `DELAY_HALF_BASE;
      end
    end
  endfunction

  // Address space match for a window's space field
  function space_ok;
    input [1:0] space;
    input [5:0] am;
    input [5:0] user_am;
    begin
      case (space)
        `SPACE_A32: space_ok = (am[5:4] == 2'h0);
        `SPACE_A24: space_ok = (am[5:4] == 2'h3);
        `SPACE_A16: space_ok = (am[5:3] == 3'h5);
        default:    space_ok = (am == user_am);
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers

  reg [2:0] sticky_r;
  reg       post_r;
  reg [7:0] ctl0_r;
  reg [7:0] tim0_r;
  reg [7:0] ctl1_r;
  reg [7:0] tim1_r;
  reg       lane_r;
  reg [23:0] tmr_cnt_r;
  wire [7:0] status_view;

  wire wr_status = reg_wr & (reg_addr == `OFF_DMA_STATUS);

  // Sticky flags: set beats a clearing write in the same cycle
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sticky_r <= 3'h0;
      post_r   <= 1'b0;
    end else if (clk_en) begin
      sticky_r[0] <= blt_interleave_active |
                     (sticky_r[0] & ~(wr_status & ~reg_wdata[`DS_BLT_BUSY]));
      sticky_r[1] <= (dma_active & ~local_bus_error_n) |
                     (sticky_r[1] & ~(wr_status & ~reg_wdata[`DS_DMA_LOCAL_BUS_ERROR_N]));
      sticky_r[2] <= (dma_active & ~backplane_berr_n) |
                     (sticky_r[2] & ~(wr_status & ~reg_wdata[`DS_DMA_BERR]));
      // Cleared like the others so software can rearm it
      post_r      <= master_post_stored |
                     (post_r & ~(wr_status & ~reg_wdata[`DS_POST_STORED]));
    end
  end

  // Configuration writes
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctl0_r <= `RST_CONTROL;
      tim0_r <= `RST_TIMING;
      ctl1_r <= `RST_CONTROL;
      tim1_r <= `RST_TIMING;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        `OFF_SW0_CONTROL: ctl0_r <= reg_wdata;
        `OFF_SW0_TIMING:  tim0_r <= reg_wdata;
        `OFF_SW1_CONTROL: ctl1_r <= reg_wdata;
        `OFF_SW1_TIMING:  tim1_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Status view: mirrors and reserved ones
  assign status_view = {post_r, 2'b11, berr_status, local_bus_error_n_status, sticky_r};

  // Read data one cycle after the strobe, zero otherwise and for holes
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd) begin
        case (reg_addr)
          `OFF_DMA_STATUS:  reg_rdata <= status_view;
          `OFF_SW0_CONTROL: reg_rdata <= ctl0_r;
          `OFF_SW0_TIMING:  reg_rdata <= tim0_r;
          `OFF_SW1_CONTROL: reg_rdata <= ctl1_r;
          `OFF_SW1_TIMING:  reg_rdata <= tim1_r;
          default:          reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slave decode

  // Window choice; window 0 wins if both are selected
  reg       sel0;
  reg       sel_any;
  reg [7:0] ctl_sel;
  reg       ok;
  always @* begin
    sel0    = ~slave_window0_select_n;
    sel_any = sel0 | ~slave_window1_select_n;
    ctl_sel = sel0 ? ctl0_r : ctl1_r;
    ok      = space_ok(ctl_sel[`CR_SPACE_LO+1:`CR_SPACE_LO], am_code,
                       address_modifier_source);
    if (ctl_sel[`CR_SUPER] && !am_code[`AM_SUPER_BIT]) begin
      ok = 1'b0;
    end
    if (access_d32 && !ctl_sel[`CR_D32]) begin
      ok = 1'b0;
    end
    if (am_is_block && (ctl_sel[1:0] != `MODE_EMULATE) && (ctl_sel[1:0] != `MODE_HOLD)) begin
      ok = 1'b0;
    end
  end

  // Registered decode answers and local strobe style
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      slave_accept                <= 1'b0;
      slave_berr                  <= 1'b0;
      local_address_strobe_hold   <= 1'b0;
      local_address_strobe_toggle <= 1'b0;
      master_dma_block_en         <= 1'b0;
      master_post_en              <= 1'b0;
      slave_post_en               <= 1'b0;
    end else if (clk_en) begin
      slave_accept                <= sel_any & ok;
      slave_berr                  <= sel_any & ~ok;
      local_address_strobe_toggle <= sel_any & am_is_block & ok &
                                     (ctl_sel[1:0] == `MODE_EMULATE);
      local_address_strobe_hold   <= sel_any & am_is_block & ok &
                                     (ctl_sel[1:0] == `MODE_HOLD);
      // DMA master blocks follow window 0 only
      master_dma_block_en         <= (ctl0_r[1:0] == `MODE_EMULATE) |
                                     (ctl0_r[1:0] == `MODE_HOLD);
      master_post_en              <= ctl1_r[`CR_MPOST];
      slave_post_en               <= ctl1_r[`CR_SPOST];
    end
  end

  // D16 block lanes: alternate per beat with D32 set, swap only otherwise
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lane_r                    <= 1'b0;
      byte_lane_buffer_enable_n <= 1'b1;
      swap_data_enable_n        <= 1'b1;
    end else if (clk_en) begin
      if (block_cycle_start) begin
        lane_r <= 1'b0;
      end else if (block_beat) begin
        lane_r <= ~lane_r;
      end
      if (sel0 && am_is_block && !access_d32 && block_beat) begin
        if (ctl0_r[`CR_D32]) begin
          byte_lane_buffer_enable_n <= lane_r;
          swap_data_enable_n        <= ~lane_r;
        end else begin
          byte_lane_buffer_enable_n <= 1'b1;
          swap_data_enable_n        <= 1'b0;
        end
      end else if (!block_beat) begin
        byte_lane_buffer_enable_n <= 1'b1;
        swap_data_enable_n        <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Periodic interrupt 2 square wave

  reg [23:0] half_cnt;
  always @* begin
    case (ctl0_r[7:6])
      2'h1:    half_cnt = HALF_50_CNT;
      2'h2:    half_cnt = HALF_1000_CNT;
      2'h3:    half_cnt = HALF_100_CNT;
      default: half_cnt = 24'h00_0000;
    endcase
  end

  // Disabled timer parks the output high; servicing it is up to the interrupt control
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tmr_cnt_r          <= 24'h00_0000;
      local_interrupt2_n <= 1'b1;
    end else if (clk_en) begin
      if (ctl0_r[7:6] == 2'h0) begin
        tmr_cnt_r          <= 24'h00_0000;
        local_interrupt2_n <= 1'b1;
      end else if (tmr_cnt_r + 24'h00_0001 >= half_cnt) begin
        tmr_cnt_r          <= 24'h00_0000;
        local_interrupt2_n <= ~local_interrupt2_n;
      end else begin
        tmr_cnt_r <= tmr_cnt_r + 24'h00_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Delay outputs

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      single_access_delay      <= 5'h00;
      slave_block_first_delay  <= 5'h00;
      slave_block_next_delay   <= 5'h00;
      master_block_first_delay <= 5'h00;
      master_block_next_delay  <= 5'h00;
      module_dma_first_delay   <= 5'h00;
      module_dma_next_delay    <= 5'h00;
    end else if (clk_en) begin
      // Slave delays follow the selected window
      if (!slave_window1_select_n && slave_window0_select_n) begin
        single_access_delay     <= delay_halves(tim1_r[3:0]);
        slave_block_first_delay <= delay_halves(tim1_r[3:0]);
        slave_block_next_delay  <= delay_halves(tim1_r[7:4]);
      end else begin
        single_access_delay     <= delay_halves(tim0_r[3:0]);
        slave_block_first_delay <= delay_halves(tim0_r[3:0]);
        slave_block_next_delay  <= delay_halves(tim0_r[7:4]);
      end
      master_block_first_delay <= delay_halves(tim0_r[3:0]);
      master_block_next_delay  <= delay_halves(tim0_r[7:4]);
      module_dma_first_delay   <= delay_halves(tim0_r[3:0]);
      module_dma_next_delay    <= delay_halves(tim0_r[7:4]);
    end
  end

endmodule
`default_nettype wire

// >>> backplane_master_model.sv
// Backplane master and local responder model facing the slave-select bank
`timescale 1ns/1ns
`default_nettype none
module backplane_master_model (
  input  wire logic       clk_sys,
  input  wire logic       hold,
  input  wire logic       toggle,
  output var  logic       sel0_n,
  output var  logic       sel1_n,
  output var  logic [5:0] am,
  output var  logic       blk,
  output var  logic       d32,
  output var  logic       beat,
  output var  logic       start,
  output var  logic       ack_n
);
  // Idle bus: nothing selected
  initial {sel0_n, sel1_n, am, blk, d32, beat, start} = {2'h3, 6'h2A, 4'h0};
  // One access; n extra beats keep the select down for a block
  task automatic burst(input logic w, input logic [5:0] a, input logic b, d, input int n);
    @(posedge clk_sys);
    {sel0_n, sel1_n, am, blk, d32, start} <= {w, ~w, a, b, d, 1'h1};
    repeat (n) @(posedge clk_sys) {beat, start} <= {b, 1'h0};
    @(posedge clk_sys);
    // Released lines show the inverse modifier, so a stale copy never matches
    {sel0_n, sel1_n, am, blk, beat, start} <= {2'h3, ~a, 3'h0};
  endtask
  // Ack held down in hold mode, pulsed per strobe in emulation
  always @(posedge clk_sys) ack_n <= hold ? 1'h0 : (toggle ? ~ack_n : 1'h1);
endmodule
`default_nettype wire

// >>> slave_select_bank_properties.sv
// Concurrent checks on the ports of the slave-select bank
`timescale 1ns/1ns
`default_nettype none
`include "slave_select_defs.vh"
module slave_select_bank_properties (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       local_bus_error_n_status,
  input wire logic       berr_status,
  input wire logic       slave_window0_select_n,
  input wire logic [5:0] am_code,
  input wire logic       am_is_block,
  input wire logic       slave_accept,
  input wire logic       slave_berr,
  input wire logic       local_address_strobe_hold,
  input wire logic       local_address_strobe_toggle,
  input wire logic       local_interrupt2_n
);
  logic [7:0] ctl0_r;
  // Shadow of window 0 control so decode checks know the mode
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctl0_r <= 8'h00;
    end else if (clk_en && reg_wr && reg_addr == `OFF_SW0_CONTROL) begin
      ctl0_r <= reg_wdata;
    end
  end
  wire logic sel_w0 = clk_en && !slave_window0_select_n;
  wire logic st_rd  = clk_en && reg_rd && reg_addr == `OFF_DMA_STATUS;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  //////////////////////////////
  AST_RD_IDLE: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_RSVD_ONES: assert property (st_rd |=> reg_rdata[6:5] == 2'h3)
    else $error("reserved status bits not one");
  AST_ERR_COPY: assert property (st_rd |=> reg_rdata[4:3] == $past({berr_status, local_bus_error_n_status}))
    else $error("error copies wrong in status");
  AST_MODE0_BLOCK: assert property (sel_w0 && am_is_block && ctl0_r[1:0] == 2'h0 |=> slave_berr && !slave_accept)
    else $error("block accepted in mode none");
  AST_SUPER_ONLY: assert property (sel_w0 && ctl0_r[5] && !am_code[2] |=> slave_berr && !slave_accept)
    else $error("user access not refused");
  AST_HOLD_MODE: assert property (sel_w0 && am_is_block && ctl0_r[1:0] == 2'h2
    |=> local_address_strobe_hold == slave_accept && !local_address_strobe_toggle)
    else $error("strobe hold wrong");
  AST_TOGGLE_MODE: assert property (sel_w0 && am_is_block && ctl0_r[1:0] == 2'h1
    |=> local_address_strobe_toggle == slave_accept && !local_address_strobe_hold)
    else $error("strobe toggle wrong");
  AST_TIMER_OFF: assert property (ctl0_r[7:6] == 2'h0 [*3] |=> local_interrupt2_n)
    else $error("interrupt active while timer off");
  // Main scenarios reached
  cover property (sel_w0 && am_is_block ##1 slave_accept);
  cover property (st_rd);
  cover property ($fell(local_interrupt2_n));
endmodule
bind slave_select_bank slave_select_bank_properties chk_u (.clk_sys, .nrst, .clk_en, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .local_bus_error_n_status, .berr_status, .slave_window0_select_n, .am_code, .am_is_block,
  .slave_accept, .slave_berr, .local_address_strobe_hold, .local_address_strobe_toggle, .local_interrupt2_n);
`default_nettype wire

// >>> slave_select_bank_bench.sv
// Self-checking bench for the slave-select status and configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "slave_select_defs.vh"
module slave_select_bank_bench;
  localparam logic [7:0] S = `OFF_DMA_STATUS, C0 = `OFF_SW0_CONTROL, C1 = `OFF_SW1_CONTROL;
  logic       clk_sys = 1'h0, nrst = 1'h0, clk_en = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, blt = 1'h0;
  logic       dma_active = 1'h0, lbe_n = 1'h1, bpe_n = 1'h1, local_bus_error_n_status = 1'h0, berr_status = 1'h0, post = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [5:0] ams = 6'h00, am;
  logic       sel0_n, sel1_n, blk, d32, beat, start, acc, err, mdma, hold, tog, lane_n, swap_n, irq_n;
  logic       mpost, spost;
  logic [4:0] d_sa, d_sb0, d_sb1, d_mb0, d_mb1, d_md0, d_md1;
  int         fail_count = 0, checked = 0;
  slave_select_bank #(.HALF_50_CNT(24'h00_000A), .HALF_1000_CNT(24'h00_0005), .HALF_100_CNT(24'h00_0008)) dut_u (
    .clk_sys, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .dma_active,
    .blt_interleave_active(blt), .local_bus_error_n(lbe_n), .backplane_berr_n(bpe_n), .local_bus_error_n_status,
    .berr_status, .master_post_stored(post), .address_modifier_source(ams), .slave_window0_select_n(sel0_n),
    .slave_window1_select_n(sel1_n), .am_code(am), .am_is_block(blk), .access_d32(d32), .block_beat(beat),
    .block_cycle_start(start), .slave_accept(acc), .slave_berr(err), .master_dma_block_en(mdma),
    .local_address_strobe_hold(hold), .local_address_strobe_toggle(tog), .byte_lane_buffer_enable_n(lane_n),
    .swap_data_enable_n(swap_n), .local_interrupt2_n(irq_n), .master_post_en(mpost), .slave_post_en(spost),
    .single_access_delay(d_sa), .slave_block_first_delay(d_sb0), .slave_block_next_delay(d_sb1),
    .master_block_first_delay(d_mb0), .master_block_next_delay(d_mb1), .module_dma_first_delay(d_md0),
    .module_dma_next_delay(d_md1));
  backplane_master_model bp_u (.clk_sys, .hold, .toggle(tog), .sel0_n, .sel1_n, .am, .blk, .d32, .beat,
    .start, .ack_n());
  // Clock
  always #5 clk_sys = ~clk_sys;
  //////////////////////////////
  task automatic chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
    @(posedge clk_sys) reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk_sys) {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge clk_sys) reg_rd <= 1'h0;
    #1 chk(reg_rdata, exp);
  endtask
  // Expected delay in half periods: code 0 none, else 2.0 plus half steps
  function automatic logic [7:0] dly(input logic [3:0] n);
    return (n == 4'h0) ? 8'h00 : {4'h0, n} + 8'h03;
  endfunction
  //////////////////////////////
  task automatic t_regs;
    rd(S, 8'h60);
    rd(8'hC0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(C0 + 8'(4 * i), 8'h00);
      wr(C0 + 8'(4 * i), 8'hA5);
      rd(C0 + 8'(4 * i), 8'hA5);
    end
    // Frozen clock enable must swallow a write
    @(posedge clk_sys) clk_en <= 1'h0;
    wr(C0, 8'h3C);
    @(posedge clk_sys) clk_en <= 1'h1;
    rd(C0, 8'hA5);
  endtask
  // Sticky flags, their qualifiers, mirrors and clearing
  task automatic t_status;
    wr(C1, 8'h00);
    @(posedge clk_sys) lbe_n <= 1'h0;
    @(posedge clk_sys) {lbe_n, blt} <= 2'h3;
    @(posedge clk_sys) blt <= 1'h0;
    rd(S, 8'h61);
    wr(S, 8'hFF);
    rd(S, 8'h61);
    wr(S, 8'h00);
    rd(S, 8'h60);
    @(posedge clk_sys) {dma_active, lbe_n} <= 2'h2;
    @(posedge clk_sys) {lbe_n, bpe_n} <= 2'h2;
    @(posedge clk_sys) {dma_active, bpe_n} <= 2'h1;
    rd(S, 8'h66);
    wr(S, 8'hFB);
    rd(S, 8'h62);
    @(posedge clk_sys) {local_bus_error_n_status, berr_status, post} <= 3'h7;
    @(posedge clk_sys) post <= 1'h0;
    rd(S, 8'hFA);
    @(posedge clk_sys) {local_bus_error_n_status, berr_status} <= 2'h0;
    wr(S, 8'h00);
    rd(S, 8'h60);
  endtask
  task automatic t_delays;
    wr(`OFF_SW1_TIMING, 8'hF7);
    for (int n = 0; n < 16; n++) begin
      wr(`OFF_SW0_TIMING, {~4'(n), 4'(n)});
      @(posedge clk_sys);
      #1 chk({3'h0, d_mb0}, dly(4'(n)));
      chk({3'h0, d_md0}, dly(4'(n)));
      chk({3'h0, d_sa}, dly(4'(n)));
      chk({3'h0, d_mb1}, dly(~4'(n)));
      chk({3'h0, d_md1}, dly(~4'(n)));
      chk({3'h0, d_sb1}, dly(~4'(n)));
    end
    bp_u.burst(1'h0, 6'h0D, 1'h0, 1'h0, 0);
    #1 chk({3'h0, d_sb0}, dly(4'hF));
    bp_u.burst(1'h1, 6'h0D, 1'h0, 1'h0, 0);
    #1 chk({3'h0, d_sa}, dly(4'h7));
    chk({3'h0, d_sb0}, dly(4'h7));
  endtask
  task automatic dec(input logic [7:0] a, c, input logic [5:0] m, input logic b, d, ea, ee);
    wr(a, c);
    bp_u.burst(a == C1, m, b, d, 0);
    #1 chk({6'h0, acc, err}, {6'h0, ea, ee});
  endtask
  task automatic t_decode;
    dec(C0, 8'h00, 6'h0D, 0, 0, 1, 0);
    dec(C0, 8'h00, 6'h0F, 1, 0, 0, 1);
    chk({7'h0, mdma}, 8'h00);
    dec(C0, 8'h04, 6'h3D, 0, 0, 1, 0);
    dec(C0, 8'h08, 6'h2D, 0, 0, 1, 0);
    @(posedge clk_sys) ams <= 6'h15;
    dec(C0, 8'h0C, 6'h15, 0, 0, 1, 0);
    dec(C0, 8'h20, 6'h09, 0, 0, 0, 1);
    dec(C0, 8'h20, 6'h0D, 0, 0, 1, 0);
    dec(C0, 8'h00, 6'h0D, 0, 1, 0, 1);
    dec(C0, 8'h10, 6'h0D, 0, 1, 1, 0);
    dec(C0, 8'h01, 6'h0F, 1, 0, 1, 0);
    chk({6'h0, tog, mdma}, 8'h03);
    dec(C0, 8'h02, 6'h0F, 1, 0, 1, 0);
    chk({6'h0, hold, mdma}, 8'h03);
    dec(C0, 8'h03, 6'h0F, 1, 0, 0, 1);
    dec(C1, 8'h00, 6'h0F, 1, 0, 0, 1);
    dec(C1, 8'h01, 6'h0F, 1, 0, 1, 0);
    dec(C1, 8'h25, 6'h39, 0, 0, 0, 1);
    dec(C1, 8'h14, 6'h3D, 0, 1, 1, 0);
    dec(C1, 8'hC0, 6'h0D, 0, 0, 1, 0);
    chk({6'h0, mpost, spost}, 8'h03);
    wr(C1, 8'h40);
    @(posedge clk_sys);
    #1 chk({6'h0, mpost, spost}, 8'h02);
  endtask
  // D16 block of six beats; which lane enables were ever driven
  task automatic lanes(input logic [7:0] c, input logic [7:0] exp);
    logic sl, ss;
    {sl, ss} = 2'h0;
    wr(C0, c);
    // Watch the enables while the block runs and a little after
    fork
      bp_u.burst(1'h0, 6'h0F, 1'h1, 1'h0, 6);
      repeat (10) @(posedge clk_sys) #1 {sl, ss} = {sl | ~lane_n, ss | ~swap_n};
    join
    chk({6'h0, sl, ss}, exp);
  endtask
  // Cycles between two output edges; 60 means it never moved
  task automatic tmr(input logic [7:0] c, exp);
    int n;
    logic v;
    wr(C0, c);
    repeat (25) @(posedge clk_sys);
    #1 for (int k = 0; k < 2; k++) begin
      v = irq_n;
      n = 0;
      while (irq_n === v && n < 60) begin
        @(posedge clk_sys);
        #1 n++;
      end
    end
    chk(8'(n), exp);
  endtask
  task automatic t_timer;
    tmr(8'h40, 8'h0A);
    tmr(8'h80, 8'h05);
    tmr(8'hC0, 8'h08);
    tmr(8'h00, 8'h3C);
    chk({7'h0, irq_n}, 8'h01);
  endtask
  //////////////////////////////
  task automatic end_of_test;
    if (fail_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'h1;
    t_regs;
    t_status;
    t_delays;
    t_decode;
    lanes(8'h11, 8'h03);
    lanes(8'h01, 8'h01);
    t_timer;
    end_of_test;
  end
  // Watchdog: the tests need well under a fifth of this span
  initial begin
    #100000;
    fail_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
